// ---- rtl/pllipc_pkg.sv ----
// Constants and types shared by the PLL input and phase control block
package pllipc_pkg;

    // Register addresses
    localparam logic [8:0] ADDR_CONTROL_MAIN = 9'h100;
    localparam logic [8:0] ADDR_INTEGER_DIVIDER = 9'h101;
    localparam logic [8:0] ADDR_INPUT_SELECT = 9'h102;
    localparam logic [8:0] ADDR_PHASE_STEP = 9'h103;
    localparam logic [8:0] ADDR_FEEDBACK_CONFIG = 9'h105;

    // Reset values
    localparam logic [7:0] RST_CONTROL_MAIN = 8'h00;
    localparam logic [7:0] RST_INTEGER_DIVIDER = 8'h04;
    localparam logic [7:0] RST_INPUT_SELECT = 8'h03;
    localparam logic [7:0] RST_PHASE_STEP = 8'h00;
    localparam logic [7:0] RST_FEEDBACK_CONFIG = 8'h05;

    // Writable bits; the rest read as zero
    localparam logic [7:0] MASK_INTEGER_DIVIDER = 8'h0F;
    localparam logic [7:0] MASK_FEEDBACK_CONFIG = 8'hF7;

    // pll_control_main fields
    localparam int BIT_FREQ_STEP_ENABLE = 7;
    localparam int BIT_DIVIDER_ALIGN = 6;
    localparam int LSB_SWITCH_GPIO_SELECT = 4;
    localparam int BIT_SPREAD_TARGET = 3;
    localparam int BIT_FRAC_DIVIDER_ENABLE = 2;
    localparam int BIT_BYPASS = 1;
    localparam int BIT_INPUT_DOUBLER_ENABLE = 0;

    // pll_integer_divider field
    localparam int LSB_INTEGER_DIVIDER = 0;

    // pll_input_select fields
    localparam int BIT_MONITOR_SWITCH_MODE = 7;
    localparam int BIT_PIN_SWITCH_MODE = 6;
    localparam int LSB_ALTERNATE_SOURCE = 3;
    localparam int LSB_PRIMARY_SOURCE = 0;

    // pll_phase_step fields
    localparam int BIT_PHASE_DOWN = 7;
    localparam int LSB_PHASE_DOWN_SOURCE = 4;
    localparam int BIT_PHASE_UP = 3;
    localparam int LSB_PHASE_UP_SOURCE = 0;

    // pll_feedback_config fields
    localparam int BIT_EXTERNAL_FEEDBACK = 7;
    localparam int LSB_FEEDBACK_PATH_SELECT = 5;
    localparam int BIT_READ_LIVE_DIVIDER = 4;
    localparam int LSB_DIVIDER_WRITE_LENGTH = 0;

    // Sizes
    localparam int GPIO_COUNT = 4;
    localparam int OUTPUT_COUNT = 10;

    // Reference source codes
    localparam logic [2:0] SRC_INPUT_CLOCK_1 = 3'h0;
    localparam logic [2:0] SRC_INPUT_CLOCK_2 = 3'h1;
    localparam logic [2:0] SRC_INPUT_CLOCK_3 = 3'h2;
    localparam logic [2:0] SRC_CRYSTAL = 3'h3;
    localparam logic [2:0] SRC_CRYSTAL_DOUBLED = 3'h4;

    // Phase step source codes
    localparam logic [2:0] STEP_SRC_REGISTER = 3'h0;
    localparam logic [2:0] STEP_SRC_GPIO_FIRST = 3'h1;
    localparam logic [2:0] STEP_SRC_GPIO_LAST = 3'h4;

    // Integer divider ratio, expressed in half steps
    localparam logic [3:0] INTEGER_DIVIDER_UNIT_STEP_FIRST = 4'h8;
    localparam logic [4:0] DIV_HALF_BASE = 5'h08;

    // Last feedback divider byte is the field plus this
    localparam logic [3:0] WRITE_LENGTH_OFFSET = 4'h1;

    typedef enum logic {
        SEL_PRIMARY,
        SEL_ALTERNATE
    } pllipc_sel_t;

endpackage

// ---- rtl/pllipc_sync.sv ----
// Two-stage synchroniser for the GPIO control pins
`timescale 1ns/1ps
module pllipc_sync
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Pins and synchronised copy
    input wire logic [pllipc_pkg::GPIO_COUNT-1:0] gpio_i,
    output logic [pllipc_pkg::GPIO_COUNT-1:0] gpio_sync_o
);
    import pllipc_pkg::*;

    typedef struct packed {
        logic [GPIO_COUNT-1:0] stage1;
        logic [GPIO_COUNT-1:0] stage2;
    } pllipc_sync_state_t;

    pllipc_sync_state_t st_r;
    pllipc_sync_state_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.stage1 = gpio_i;
        st_nxt.stage2 = st_r.stage1;
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign gpio_sync_o = st_r.stage2;

    default clocking sync_cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);

    a_sync_two_stage: assert property ($past(reset_n_i, 2) |-> gpio_sync_o == $past(gpio_i, 2))
    else $error("Synchronised GPIO does not lag the pin by two cycles");

endmodule

// ---- rtl/pllipc_step.sv ----
// Turns every change of a step control level into one step pulse
`timescale 1ns/1ps
module pllipc_step
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Control level and resulting pulse
    input wire logic level_i,
    output logic step_o
);
    import pllipc_pkg::*;

    typedef struct packed {
        logic level_d;
        logic step;
    } pllipc_step_state_t;

    pllipc_step_state_t st_r;
    pllipc_step_state_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.level_d = level_i;
        // Both edges count
        st_nxt.step = level_i ^ st_r.level_d;
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign step_o = st_r.step;

    default clocking step_cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);

    a_step_each_edge: assert property ($changed(level_i) |=> step_o)
    else $error("Level change gave no step pulse");

    a_step_no_spurious: assert property ($stable(level_i) |=> !step_o)
    else $error("Step pulse without a level change");

endmodule

// ---- rtl/pllipc_top.sv ----
// PLL reference selection, divider and phase step control registers
`timescale 1ns/1ps

// Contract
// - Rising divider_align resets all phase-enabled output dividers together.
// - That common reset lets integer-related enabled outputs align edges.
// - switch_gpio_select picks GPIO0..3 as switch control, only in pin mode.
// - spread_target sends modulation to feedback divider (0) or output divider (1).
// - Fractional divider active only when globally enabled, enabled and not bypassed.
// - Bypass bit picks fractional divider output (0) or bypass path (1).
// - input_doubler_enable inserts a doubler ahead of the PLL input.
// - freq_step_enable gates frequency increment and decrement.
// - Integer divider: 4 to 7.5 by halves, then 8 to 15; resets to 6.
// - Monitor mode moves to alternate source on primary loss of signal.
// - Pin mode: GPIO low uses primary source, high uses alternate.
// - Monitor switching acts only when pin switching is off.
// - Alternate source codes: inputs 1-3, crystal, crystal doubled; resets 000.
// - Primary source uses same codes, drives mux by default, resets 011.
// - Phase down source: register bit for 000, GPIO0..3 for 001..100.
// - Each edge of selected down signal steps phase down once.
// - Phase up source: register bit for 000, GPIO0..3 for 001..100.
// - Each edge of selected up signal steps phase up once.
// - With external feedback, select input clock 1-3 or output 1 path.
// - Write-length field names last committing byte, field plus one; resets 5.
// - read_live_divider picks written value (0) or stepped value (1).
module pllipc_top
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,

    // Register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [8:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,

    // Device inputs
    input wire logic [pllipc_pkg::GPIO_COUNT-1:0] gpio_i,
    input wire logic primary_los_i,
    input wire logic pll_global_enable_i,
    input wire logic [pllipc_pkg::OUTPUT_COUNT-1:0] output_phase_enable_i,

    // Output divider alignment
    output logic [pllipc_pkg::OUTPUT_COUNT-1:0] divider_reset_o,

    // PLL and divider controls
    output logic freq_step_enable_o,
    output logic spread_target_o,
    output logic frac_divider_active_o,
    output logic bypass_o,
    output logic input_doubler_enable_o,
    output logic [3:0] integer_divider_o,
    output logic [4:0] divide_half_steps_o,

    // Reference selection
    output logic [2:0] pll_source_o,
    output logic selected_alternate_o,

    // Phase steps
    output logic phase_up_o,
    output logic phase_down_o,

    // Feedback configuration
    output logic external_feedback_enable_o,
    output logic [1:0] feedback_path_select_o,
    output logic read_live_divider_o,
    output logic [2:0] divider_write_length_o,
    output logic [3:0] last_divider_byte_o
);
    import pllipc_pkg::*;

    typedef struct packed {
        logic [7:0] control_main;
        logic [7:0] integer_divider;
        logic [7:0] input_select;
        logic [7:0] phase_step;
        logic [7:0] feedback_config;

        logic [7:0] rdata;
        logic align_d;
        logic [OUTPUT_COUNT-1:0] divider_reset;
        logic frac_active;
        logic [4:0] div_half;
        logic [3:0] last_byte;
        pllipc_sel_t sel;
        logic [2:0] source;
    } pllipc_state_t;

    localparam pllipc_state_t ST_RESET = '{
        control_main: RST_CONTROL_MAIN,
        integer_divider: RST_INTEGER_DIVIDER,
        input_select: RST_INPUT_SELECT,
        phase_step: RST_PHASE_STEP,
        feedback_config: RST_FEEDBACK_CONFIG,

        rdata: 8'h00,
        align_d: 1'b0,
        divider_reset: '0,
        frac_active: 1'b0,
        div_half: 5'h0C,
        last_byte: 4'h6,
        sel: SEL_PRIMARY,
        source: RST_INPUT_SELECT[2:0]
    };

    pllipc_state_t st_r;
    pllipc_state_t st_nxt;

    logic [GPIO_COUNT-1:0] gpio_sync;
    logic switch_level;
    logic [1:0] step_level;
    logic [1:0] step_pulse;

    // Level of a phase step source; unused codes give a steady low
    function automatic logic step_source_level(
        input logic [2:0] code,
        input logic reg_bit,
        input logic [GPIO_COUNT-1:0] pins
    );
        logic level;
        level = 1'b0;
        if (code == STEP_SRC_REGISTER)
        begin
            level = reg_bit;
        end
        else if (code >= STEP_SRC_GPIO_FIRST && code <= STEP_SRC_GPIO_LAST)
        begin
            level = pins[2'(code - STEP_SRC_GPIO_FIRST)];
        end
        return level;
    endfunction

    pllipc_sync u_sync
    (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .gpio_i(gpio_i),
        .gpio_sync_o(gpio_sync)
    );

    assign switch_level = gpio_sync[st_r.control_main[LSB_SWITCH_GPIO_SELECT +: 2]];

    assign step_level[0] = step_source_level(st_r.phase_step[LSB_PHASE_UP_SOURCE +: 3],
        st_r.phase_step[BIT_PHASE_UP], gpio_sync);
    assign step_level[1] = step_source_level(st_r.phase_step[LSB_PHASE_DOWN_SOURCE +: 3],
        st_r.phase_step[BIT_PHASE_DOWN], gpio_sync);

    // Index 0 steps phase up, index 1 steps it down
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_step
            pllipc_step u_step
            (
                .clk_sys_i(clk_sys_i),
                .reset_n_i(reset_n_i),
                .level_i(step_level[g]),
                .step_o(step_pulse[g])
            );
        end
    endgenerate

    always_comb
    begin
        st_nxt = st_r;

        // Writes to unmapped addresses are dropped
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                ADDR_CONTROL_MAIN: st_nxt.control_main = reg_wdata_i;
                ADDR_INTEGER_DIVIDER: st_nxt.integer_divider = reg_wdata_i & MASK_INTEGER_DIVIDER;
                ADDR_INPUT_SELECT: st_nxt.input_select = reg_wdata_i;
                ADDR_PHASE_STEP: st_nxt.phase_step = reg_wdata_i;
                ADDR_FEEDBACK_CONFIG: st_nxt.feedback_config = reg_wdata_i & MASK_FEEDBACK_CONFIG;
                default: st_nxt.control_main = st_r.control_main;
            endcase
        end

        // Read data holds until the next read
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                ADDR_CONTROL_MAIN: st_nxt.rdata = st_r.control_main;
                ADDR_INTEGER_DIVIDER: st_nxt.rdata = st_r.integer_divider;
                ADDR_INPUT_SELECT: st_nxt.rdata = st_r.input_select;
                ADDR_PHASE_STEP: st_nxt.rdata = st_r.phase_step;
                ADDR_FEEDBACK_CONFIG: st_nxt.rdata = st_r.feedback_config;
                default: st_nxt.rdata = 8'h00;
            endcase
        end

        // One reset for all enabled outputs on a rising align bit only
        st_nxt.align_d = st_r.control_main[BIT_DIVIDER_ALIGN];
        st_nxt.divider_reset = '0;
        if (st_r.control_main[BIT_DIVIDER_ALIGN] && !st_r.align_d)
        begin
            st_nxt.divider_reset = output_phase_enable_i;
        end

        // Any one gate switches the divider off to save power
        st_nxt.frac_active = pll_global_enable_i
            && st_r.control_main[BIT_FRAC_DIVIDER_ENABLE]
            && !st_r.control_main[BIT_BYPASS];

        // Codes below eight step by halves
        if (st_r.integer_divider[3:0] < INTEGER_DIVIDER_UNIT_STEP_FIRST)
        begin
            st_nxt.div_half = DIV_HALF_BASE + {1'b0, st_r.integer_divider[3:0]};
        end
        else
        begin
            st_nxt.div_half = {st_r.integer_divider[3:0], 1'b0};
        end

        // Field counts from zero, bytes from one
        st_nxt.last_byte = {1'b0, st_r.feedback_config[LSB_DIVIDER_WRITE_LENGTH +: 3]}
            + WRITE_LENGTH_OFFSET;

        // Pin switching outranks monitor switching
        if (st_r.input_select[BIT_PIN_SWITCH_MODE])
        begin
            st_nxt.sel = switch_level ? SEL_ALTERNATE : SEL_PRIMARY;
        end
        else if (st_r.input_select[BIT_MONITOR_SWITCH_MODE] && primary_los_i)
        begin
            st_nxt.sel = SEL_ALTERNATE;
        end
        else
        begin
            st_nxt.sel = SEL_PRIMARY;
        end

        unique case (st_nxt.sel)
            SEL_PRIMARY: st_nxt.source = st_r.input_select[LSB_PRIMARY_SOURCE +: 3];
            SEL_ALTERNATE: st_nxt.source = st_r.input_select[LSB_ALTERNATE_SOURCE +: 3];
        endcase
    end

    // Whole state in one register
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            st_r <= ST_RESET;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Every output except phase_up_o and phase_down_o comes from the state register
    assign reg_rdata_o = st_r.rdata;
    assign divider_reset_o = st_r.divider_reset;

    assign freq_step_enable_o = st_r.control_main[BIT_FREQ_STEP_ENABLE];
    assign spread_target_o = st_r.control_main[BIT_SPREAD_TARGET];
    assign frac_divider_active_o = st_r.frac_active;
    assign bypass_o = st_r.control_main[BIT_BYPASS];
    assign input_doubler_enable_o = st_r.control_main[BIT_INPUT_DOUBLER_ENABLE];
    assign integer_divider_o = st_r.integer_divider[LSB_INTEGER_DIVIDER +: 4];
    assign divide_half_steps_o = st_r.div_half;

    assign pll_source_o = st_r.source;
    assign selected_alternate_o = (st_r.sel == SEL_ALTERNATE);

    assign phase_up_o = step_pulse[0];
    assign phase_down_o = step_pulse[1];

    assign external_feedback_enable_o = st_r.feedback_config[BIT_EXTERNAL_FEEDBACK];
    assign feedback_path_select_o = st_r.feedback_config[LSB_FEEDBACK_PATH_SELECT +: 2];
    assign read_live_divider_o = st_r.feedback_config[BIT_READ_LIVE_DIVIDER];
    assign divider_write_length_o = st_r.feedback_config[LSB_DIVIDER_WRITE_LENGTH +: 3];
    assign last_divider_byte_o = st_r.last_byte;

    // Checks against the registered outputs
    default clocking top_cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);

    a_align_single_reset: assert property ($rose(st_r.control_main[BIT_DIVIDER_ALIGN]) |=>
        divider_reset_o == $past(output_phase_enable_i))
    else $error("Align edge did not reset exactly the phase-enabled dividers");

    a_align_held_quiet: assert property (st_r.control_main[BIT_DIVIDER_ALIGN]
        && $past(st_r.control_main[BIT_DIVIDER_ALIGN]) |=> divider_reset_o == '0)
    else $error("Held align bit caused a repeated divider reset");

    a_frac_enable_gate: assert property ($past(reset_n_i) |-> frac_divider_active_o ==
        $past(pll_global_enable_i && st_r.control_main[BIT_FRAC_DIVIDER_ENABLE]
        && !st_r.control_main[BIT_BYPASS]))
    else $error("Fractional divider activity does not follow its three conditions");

    a_int_div_ratio: assert property ($past(reset_n_i) |-> divide_half_steps_o ==
        (($past(st_r.integer_divider[3:0]) < INTEGER_DIVIDER_UNIT_STEP_FIRST)
        ? DIV_HALF_BASE + {1'b0, $past(st_r.integer_divider[3:0])}
        : {$past(st_r.integer_divider[3:0]), 1'b0}))
    else $error("Integer divider ratio wrong for its code");

    a_pin_switch_follow: assert property ($past(st_r.input_select[BIT_PIN_SWITCH_MODE])
        && $past(reset_n_i) |-> pll_source_o == ($past(switch_level)
        ? $past(st_r.input_select[LSB_ALTERNATE_SOURCE +: 3])
        : $past(st_r.input_select[LSB_PRIMARY_SOURCE +: 3])))
    else $error("Pin switching did not follow the selected GPIO level");

    a_monitor_switch_los: assert property ($past(!st_r.input_select[BIT_PIN_SWITCH_MODE]
        && st_r.input_select[BIT_MONITOR_SWITCH_MODE] && primary_los_i) && $past(reset_n_i)
        |-> selected_alternate_o)
    else $error("Loss of signal did not move to the alternate source");

    a_default_primary: assert property ($past(!st_r.input_select[BIT_PIN_SWITCH_MODE]
        && !st_r.input_select[BIT_MONITOR_SWITCH_MODE]) && $past(reset_n_i)
        |-> pll_source_o == $past(st_r.input_select[LSB_PRIMARY_SOURCE +: 3]))
    else $error("Without switching the mux did not use the primary source");

    a_write_length_byte: assert property ($past(reset_n_i) |-> last_divider_byte_o ==
        {1'b0, $past(divider_write_length_o)} + WRITE_LENGTH_OFFSET)
    else $error("Last committing byte is not the field plus one");

    // Register writes reach their outputs one cycle later
    a_spread_write: assert property (reg_wr_i && reg_addr_i == ADDR_CONTROL_MAIN |=>
        spread_target_o == $past(reg_wdata_i[BIT_SPREAD_TARGET]))
    else $error("Control write did not set the spread target");

    a_bypass_write: assert property (reg_wr_i && reg_addr_i == ADDR_CONTROL_MAIN |=>
        bypass_o == $past(reg_wdata_i[BIT_BYPASS]))
    else $error("Control write did not set the bypass bit");

    a_divider_write: assert property (reg_wr_i && reg_addr_i == ADDR_INTEGER_DIVIDER |=>
        integer_divider_o == $past(reg_wdata_i[LSB_INTEGER_DIVIDER +: 4]))
    else $error("Divider write did not land");

    a_path_write: assert property (reg_wr_i && reg_addr_i == ADDR_FEEDBACK_CONFIG |=>
        feedback_path_select_o == $past(reg_wdata_i[LSB_FEEDBACK_PATH_SELECT +: 2]))
    else $error("Feedback write did not set the path select");

endmodule

// ---- dv/pllipc_bench.sv ----
// Self-checking testbench for the PLL input and phase control block
`timescale 1ns/1ps
module pllipc_bench;
    import pllipc_pkg::*;

    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [8:0] reg_addr_i = 9'h000;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] reg_rdata_o;
    logic [GPIO_COUNT-1:0] gpio_i = '0;
    logic primary_los_i = 1'b0;
    logic pll_global_enable_i = 1'b0;
    logic [OUTPUT_COUNT-1:0] output_phase_enable_i = '0;
    logic [OUTPUT_COUNT-1:0] divider_reset_o;
    logic freq_step_enable_o;
    logic spread_target_o;
    logic frac_divider_active_o;
    logic bypass_o;
    logic input_doubler_enable_o;
    logic [3:0] integer_divider_o;
    logic [4:0] divide_half_steps_o;
    logic [2:0] pll_source_o;
    logic selected_alternate_o;
    logic phase_up_o;
    logic phase_down_o;
    logic external_feedback_enable_o;
    logic [1:0] feedback_path_select_o;
    logic read_live_divider_o;
    logic [2:0] divider_write_length_o;
    logic [3:0] last_divider_byte_o;
    int failures = 0;
    int compares = 0;
    int up_cnt = 0;
    int down_cnt = 0;
    int align_cnt = 0;
    logic [OUTPUT_COUNT-1:0] align_val = '0;

    pllipc_top dut (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .gpio_i(gpio_i), .primary_los_i(primary_los_i),
        .pll_global_enable_i(pll_global_enable_i),
        .output_phase_enable_i(output_phase_enable_i), .divider_reset_o(divider_reset_o),
        .freq_step_enable_o(freq_step_enable_o), .spread_target_o(spread_target_o),
        .frac_divider_active_o(frac_divider_active_o), .bypass_o(bypass_o),
        .input_doubler_enable_o(input_doubler_enable_o),
        .integer_divider_o(integer_divider_o), .divide_half_steps_o(divide_half_steps_o),
        .pll_source_o(pll_source_o), .selected_alternate_o(selected_alternate_o),
        .phase_up_o(phase_up_o), .phase_down_o(phase_down_o),
        .external_feedback_enable_o(external_feedback_enable_o),
        .feedback_path_select_o(feedback_path_select_o),
        .read_live_divider_o(read_live_divider_o),
        .divider_write_length_o(divider_write_length_o),
        .last_divider_byte_o(last_divider_byte_o)
    );

    initial
    begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    // Pulse counters for phase steps and divider alignment
    always @(posedge clk_sys_i)
    begin
        if (phase_up_o === 1'b1) up_cnt++;
        if (phase_down_o === 1'b1) down_cnt++;
        if (divider_reset_o !== '0)
        begin
            align_cnt++;
            align_val = divider_reset_o;
        end
    end

    task automatic tally_and_finish;
        if (failures == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1;
        chk({8'h00, reg_rdata_o}, {8'h00, exp}, what);
    endtask

    // Lets register and synchroniser latency pass before looking
    task automatic settle;
        repeat (5) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic drive_pins(input logic [GPIO_COUNT-1:0] v);
        @(posedge clk_sys_i);
        gpio_i <= v;
        settle();
    endtask

    task automatic test_reset_values;
        chk({pll_source_o, selected_alternate_o}, {3'h3, 1'b0}, "source after reset");
        chk({11'h0, divide_half_steps_o}, 16'h000C, "ratio after reset");
        chk({divider_write_length_o, last_divider_byte_o}, {9'h0, 3'h5, 4'h6}, "length");
        rd_chk(ADDR_CONTROL_MAIN, RST_CONTROL_MAIN, "control_main reset");
        rd_chk(ADDR_INTEGER_DIVIDER, RST_INTEGER_DIVIDER, "integer_divider reset");
        rd_chk(ADDR_INPUT_SELECT, RST_INPUT_SELECT, "input_select reset");
        rd_chk(ADDR_PHASE_STEP, RST_PHASE_STEP, "phase_step reset");
        rd_chk(ADDR_FEEDBACK_CONFIG, RST_FEEDBACK_CONFIG, "feedback reset");
        wr(9'h104, 8'hFF);
        rd_chk(9'h104, 8'h00, "unmapped read");
    endtask

    task automatic test_integer_divider;
        logic [4:0] e;
        for (int k = 0; k < 16; k++)
        begin
            wr(ADDR_INTEGER_DIVIDER, 8'hF0 | 8'(k));
            settle();
            e = (k < 8) ? 5'(8 + k) : 5'(2 * k);
            chk({7'h0, integer_divider_o, divide_half_steps_o}, {7'h0, 4'(k), e}, "div");
            rd_chk(ADDR_INTEGER_DIVIDER, 8'(k), "integer_divider readback");
        end
    endtask

    task automatic test_control_main;
        logic [4:0] e;
        for (int k = 0; k < 16; k++)
        begin
            @(posedge clk_sys_i);
            pll_global_enable_i <= k[3];
            wr(ADDR_CONTROL_MAIN, {k[0], 3'b000, k[0], k[1], k[2], k[1]});
            settle();
            e = {k[0], k[0], k[3] & k[1] & ~k[2], k[2], k[1]};
            chk({11'h0, freq_step_enable_o, spread_target_o, frac_divider_active_o, bypass_o,
                 input_doubler_enable_o}, {11'h0, e}, "control outputs");
        end
    endtask

    task automatic test_align;
        wr(ADDR_CONTROL_MAIN, 8'h00);
        @(posedge clk_sys_i);
        output_phase_enable_i <= 10'h2A5;
        settle();
        align_cnt = 0;
        wr(ADDR_CONTROL_MAIN, 8'h40);
        settle();
        wr(ADDR_CONTROL_MAIN, 8'h40);
        settle();
        chk(16'(align_cnt), 16'h0001, "align pulses while held");
        chk({6'h0, align_val}, 16'h02A5, "aligned outputs");
        wr(ADDR_CONTROL_MAIN, 8'h00);
        @(posedge clk_sys_i);
        output_phase_enable_i <= 10'h15A;
        wr(ADDR_CONTROL_MAIN, 8'h40);
        settle();
        chk(16'(align_cnt), 16'h0002, "second align");
        chk({6'h0, align_val}, 16'h015A, "second aligned outputs");
        wr(ADDR_CONTROL_MAIN, 8'h00);
    endtask

    task automatic test_switching;
        @(posedge clk_sys_i);
        primary_los_i <= 1'b1;
        wr(ADDR_INPUT_SELECT, 8'h11);
        drive_pins(4'hF);
        chk({12'h0, selected_alternate_o, pll_source_o}, 16'h0001, "default mux");
        wr(ADDR_INPUT_SELECT, 8'h51);
        for (int g = 0; g < GPIO_COUNT; g++)
        begin
            wr(ADDR_CONTROL_MAIN, 8'(g << 4));
            drive_pins(~(4'h1 << g));
            chk({12'h0, selected_alternate_o, pll_source_o}, 16'h0001, "pin low");
            drive_pins(4'h1 << g);
            chk({12'h0, selected_alternate_o, pll_source_o}, 16'h000A, "pin high");
        end
        drive_pins(4'h0);
        wr(ADDR_INPUT_SELECT, 8'hD1);
        settle();
        chk({12'h0, selected_alternate_o, pll_source_o}, 16'h0001, "pin wins");
        wr(ADDR_INPUT_SELECT, 8'hA1);
        settle();
        chk({12'h0, selected_alternate_o, pll_source_o}, 16'h000C, "monitor lost");
        @(posedge clk_sys_i);
        primary_los_i <= 1'b0;
        settle();
        chk({12'h0, selected_alternate_o, pll_source_o}, 16'h0001, "monitor ok");
    endtask

    task automatic test_phase_steps;
        up_cnt = 0;
        down_cnt = 0;
        wr(ADDR_PHASE_STEP, 8'h08);
        settle();
        wr(ADDR_PHASE_STEP, 8'h00);
        settle();
        wr(ADDR_PHASE_STEP, 8'h80);
        settle();
        wr(ADDR_PHASE_STEP, 8'h00);
        settle();
        chk(16'(up_cnt), 16'h0002, "register up steps");
        chk(16'(down_cnt), 16'h0002, "register down steps");
        for (int g = 0; g < GPIO_COUNT; g++)
        begin
            wr(ADDR_PHASE_STEP, 8'h11 * 8'(g + 1));
            settle();
            up_cnt = 0;
            down_cnt = 0;
            drive_pins(~(4'h1 << g));
            drive_pins(4'h0);
            chk(16'(up_cnt), 16'h0000, "other pins up");
            drive_pins(4'h1 << g);
            drive_pins(4'h0);
            chk(16'(up_cnt), 16'h0002, "pin up steps");
            chk(16'(down_cnt), 16'h0002, "pin down steps");
        end
        wr(ADDR_PHASE_STEP, 8'h55);
        settle();
        up_cnt = 0;
        down_cnt = 0;
        drive_pins(4'hF);
        drive_pins(4'h0);
        chk(16'(up_cnt + down_cnt), 16'h0000, "unused codes");
    endtask

    task automatic test_feedback;
        wr(ADDR_FEEDBACK_CONFIG, 8'hFF);
        settle();
        chk({5'h0, external_feedback_enable_o, feedback_path_select_o, read_live_divider_o,
             divider_write_length_o, last_divider_byte_o}, 16'h07F8, "feedback all");
        rd_chk(ADDR_FEEDBACK_CONFIG, 8'hF7, "feedback readback");
        wr(ADDR_FEEDBACK_CONFIG, 8'h02);
        settle();
        chk({5'h0, external_feedback_enable_o, feedback_path_select_o, read_live_divider_o,
             divider_write_length_o, last_divider_byte_o}, 16'h0023, "feedback low");
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        failures++;
        $display("[FAIL] %0t watchdog expired", $time);
        tally_and_finish();
    end

    initial
    begin
        repeat (6) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        @(posedge clk_sys_i);
        #1;
        test_reset_values();
        test_integer_divider();
        test_control_main();
        test_align();
        test_switching();
        test_phase_steps();
        test_feedback();
        tally_and_finish();
    end
endmodule
